// file: verilog/ddrcd_defines.vh
`ifndef DDRCD_DEFINES_VH
`define DDRCD_DEFINES_VH
// ==========================================
// command codes, cs/ras/cas/we order
`define DDRCD_ENC_MODE 4'h0
`define DDRCD_ENC_REFRESH 4'h1
`define DDRCD_ENC_PRECHARGE 4'h2
`define DDRCD_ENC_ACTIVATE 4'h3
`define DDRCD_ENC_WRITE 4'h4
`define DDRCD_ENC_READ 4'h5
`define DDRCD_ENC_IDLE 4'h7
// ==========================================
// decoded command output codes
`define DDRCD_CMD_NONE 3'h0
`define DDRCD_CMD_MODE 3'h1
`define DDRCD_CMD_REFRESH 3'h2
`define DDRCD_CMD_PRECHARGE 3'h3
`define DDRCD_CMD_ACTIVATE 3'h4
`define DDRCD_CMD_WRITE 3'h5
`define DDRCD_CMD_READ 3'h6
// ==========================================
// low-power states
`define DDRCD_ST_NORMAL 2'h0
`define DDRCD_ST_ACT_PD 2'h1
`define DDRCD_ST_PRE_PD 2'h2
`define DDRCD_ST_SELF_REF 2'h3
// ==========================================
// field positions and counts
`define DDRCD_FLAG_BIT 10
`define DDRCD_BURST_BEATS 3'h4
`define DDRCD_SR_READ_CLOCKS 8'd200
`endif

// file: verilog/ddrcd_command_decode.v
`timescale 1ns/1ns
`include "ddrcd_defines.vh"
module ddrcd_command_decode #(
  parameter ADDR_W = 14,
  parameter BANK_W = 3,
  parameter BANKS = 4,
  parameter DATA_W = 16
) (
  input wire ref_clk_in,
  input wire reset_n_in,
  input wire link_clk_in,
  input wire chip_sel_n_in,
  input wire row_strobe_n_in,
  input wire col_strobe_n_in,
  input wire write_en_n_in,
  input wire clk_gate_in,
  input wire [BANK_W-1:0] bank_sel_in,
  input wire [ADDR_W-1:0] addr_in,
  input wire termination_ctl_in,
  input wire write_mask_in,
  input wire [DATA_W-1:0] write_data_in,
  output reg [2:0] cmd_out,
  output reg cmd_valid_out,
  output reg [BANK_W-1:0] cmd_bank_out,
  output reg [ADDR_W-1:0] cmd_addr_out,
  output reg all_banks_out,
  output reg auto_precharge_out,
  output reg [1:0] power_state_out,
  output reg burst_busy_out,
  output reg [BANKS-1:0] open_rows_out,
  output reg read_allowed_out,
  output reg termination_on_out,
  output reg write_strobe_out,
  output reg [DATA_W-1:0] write_data_out
);

  // ==========================================
  // constants and pin positions
  localparam PIN_W = DATA_W + ADDR_W + BANK_W + 8;
  localparam BA_LSB = 8;
  localparam A_LSB = BA_LSB + BANK_W;
  localparam D_LSB = A_LSB + ADDR_W;
  localparam [1:0] ST_NORMAL = `DDRCD_ST_NORMAL;
  localparam [1:0] ST_ACT_PD = `DDRCD_ST_ACT_PD;
  localparam [1:0] ST_PRE_PD = `DDRCD_ST_PRE_PD;
  localparam [1:0] ST_SELF_REF = `DDRCD_ST_SELF_REF;
  localparam [2:0] BURST_BEATS = `DDRCD_BURST_BEATS;
  localparam [7:0] SR_CLOCKS = `DDRCD_SR_READ_CLOCKS;

  // ==========================================
  // pin synchronisers
  // link clock is bit zero; pins share its three stages so they line up with its edge
  wire [PIN_W-1:0] pin_raw;
  wire [PIN_W-1:0] pin_s3;
  wire [PIN_W-1:0] pin_agree;
  wire [PIN_W-1:0] pin_flt;
  assign pin_raw = {write_data_in, addr_in, bank_sel_in, write_mask_in, termination_ctl_in, clk_gate_in,
                    write_en_n_in, col_strobe_n_in, row_strobe_n_in, chip_sel_n_in, link_clk_in};

  genvar g;
  generate
    for (g = 0; g < PIN_W; g = g + 1) begin : pin_sync
      reg [2:0] stage;
      reg agreed;
      // no reset on the stages: they flush while reset is held
      always @(posedge ref_clk_in) begin
        stage <= {stage[1:0], pin_raw[g]};
      end
      // starts high so a link clock already high at release gives no false edge
      always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
          agreed <= 1'b1;
        end else if (stage[1] == stage[2]) begin
          agreed <= stage[2];
        end
      end
      assign pin_s3[g] = stage[2];
      assign pin_agree[g] = (stage[1] == stage[2]);
      assign pin_flt[g] = agreed;
    end
  endgenerate

  // ==========================================
  // synchronised pin levels
  // rise counts once stages two and three agree high
  wire link_rise = pin_agree[0] & pin_s3[0] & ~pin_flt[0];
  wire cs_now = pin_flt[1];
  wire ras_now = pin_flt[2];
  wire cas_now = pin_flt[3];
  wire we_now = pin_flt[4];
  wire gate_now = pin_flt[5];
  wire odt_now = pin_flt[6];
  wire mask_now = pin_flt[7];
  wire [BANK_W-1:0] ba_now = pin_flt[BA_LSB +: BANK_W];
  wire [ADDR_W-1:0] a_now = pin_flt[A_LSB +: ADDR_W];
  wire [DATA_W-1:0] d_now = pin_flt[D_LSB +: DATA_W];
  wire [3:0] enc = {cs_now, ras_now, cas_now, we_now};
  wire flag_now = a_now[`DDRCD_FLAG_BIT];

  // ==========================================
  // command decode
  reg [2:0] next_cmd;

  // termination input is not part of the decode
  always @* begin
    next_cmd = `DDRCD_CMD_NONE;
    if (cs_now) begin
      next_cmd = `DDRCD_CMD_NONE;
    end else begin
      case (enc)
        `DDRCD_ENC_MODE: next_cmd = `DDRCD_CMD_MODE;
        `DDRCD_ENC_REFRESH: next_cmd = `DDRCD_CMD_REFRESH;
        `DDRCD_ENC_PRECHARGE: next_cmd = `DDRCD_CMD_PRECHARGE;
        `DDRCD_ENC_ACTIVATE: next_cmd = `DDRCD_CMD_ACTIVATE;
        `DDRCD_ENC_WRITE: next_cmd = `DDRCD_CMD_WRITE;
        `DDRCD_ENC_READ: next_cmd = `DDRCD_CMD_READ;
        `DDRCD_ENC_IDLE: next_cmd = `DDRCD_CMD_NONE;
        default: next_cmd = `DDRCD_CMD_NONE;
      endcase
    end
  end

  // ==========================================
  // clock gate history
  reg gate_prev;
  wire gate_fall = gate_prev & ~gate_now;
  wire gate_rise = ~gate_prev & gate_now;
  wire gate_high = gate_prev & gate_now;
  wire issue = link_rise & gate_high & (next_cmd != `DDRCD_CMD_NONE);

  // resets low: the first gate-high edge after reset reads as an exit
  always @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      gate_prev <= 1'b0;
    end else if (link_rise) begin
      gate_prev <= gate_now;
    end
  end

  // ==========================================
  // low-power state
  reg [1:0] state;
  reg [1:0] next_state;
  wire all_idle = (open_rows_out == {BANKS{1'b0}});

  always @* begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        // only idle or refresh is legal on a falling gate; others are taken as idle
        if (gate_fall && next_cmd == `DDRCD_CMD_REFRESH) begin
          next_state = ST_SELF_REF;
        end else if (gate_fall && all_idle) begin
          next_state = ST_PRE_PD;
        end else if (gate_fall) begin
          next_state = ST_ACT_PD;
        end
      end
      ST_ACT_PD, ST_PRE_PD: begin
        if (gate_rise) begin
          next_state = ST_NORMAL;
        end
      end
      ST_SELF_REF: begin
        // exit taken at the sampled edge, a synchronous stand-in for an asynchronous exit
        if (gate_rise) begin
          next_state = ST_NORMAL;
        end
      end
      default: begin
        next_state = ST_NORMAL;
      end
    endcase
  end

  // while the gate stays low nothing is decoded and the state holds
  always @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      state <= ST_NORMAL;
    end else if (link_rise) begin
      state <= next_state;
    end
  end

  // ==========================================
  // self refresh exit count
  reg [7:0] sr_count;

  always @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      sr_count <= 8'h00;
    end else if (link_rise && state == ST_SELF_REF && gate_rise) begin
      sr_count <= SR_CLOCKS;
    end else if (link_rise && sr_count != 8'h00) begin
      sr_count <= sr_count - 8'h01;
    end
  end

  // ==========================================
  // command outputs
  always @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      cmd_out <= `DDRCD_CMD_NONE;
      cmd_valid_out <= 1'b0;
      cmd_bank_out <= {BANK_W{1'b0}};
      cmd_addr_out <= {ADDR_W{1'b0}};
      all_banks_out <= 1'b0;
      auto_precharge_out <= 1'b0;
    end else begin
      cmd_valid_out <= 1'b0;
      if (issue) begin
        cmd_out <= next_cmd;
        cmd_valid_out <= 1'b1;
        cmd_bank_out <= ba_now;
        cmd_addr_out <= a_now;
        all_banks_out <= (next_cmd == `DDRCD_CMD_PRECHARGE) & flag_now;
        auto_precharge_out <= ((next_cmd == `DDRCD_CMD_READ) | (next_cmd == `DDRCD_CMD_WRITE)) & flag_now;
      end
    end
  end

  // ==========================================
  // open row tracking
  // two bank bits index the four banks; the third only picks a mode register
  always @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      open_rows_out <= {BANKS{1'b0}};
    end else if (issue && next_cmd == `DDRCD_CMD_ACTIVATE) begin
      open_rows_out[ba_now[1:0]] <= 1'b1;
    end else if (issue && next_cmd == `DDRCD_CMD_PRECHARGE && flag_now) begin
      open_rows_out <= {BANKS{1'b0}};
    end else if (issue && next_cmd == `DDRCD_CMD_PRECHARGE) begin
      open_rows_out[ba_now[1:0]] <= 1'b0;
    end
  end

  // ==========================================
  // burst beats and write mask
  reg [2:0] beats;
  reg burst_write;
  wire burst_cmd = (next_cmd == `DDRCD_CMD_READ) | (next_cmd == `DDRCD_CMD_WRITE);

  always @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      beats <= 3'h0;
      burst_write <= 1'b0;
    end else if (issue && burst_cmd && beats <= 3'h1) begin
      // a new burst never cuts the running one short
      beats <= BURST_BEATS;
      burst_write <= (next_cmd == `DDRCD_CMD_WRITE);
    end else if (link_rise && beats != 3'h0) begin
      // beats advance whatever command is presented
      beats <= beats - 3'h1;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      write_strobe_out <= 1'b0;
      write_data_out <= {DATA_W{1'b0}};
    end else begin
      write_strobe_out <= 1'b0;
      if (link_rise && beats != 3'h0 && burst_write && !mask_now) begin
        write_strobe_out <= 1'b1;
        write_data_out <= d_now;
      end
    end
  end

  // ==========================================
  // status outputs
  always @* begin
    power_state_out = state;
    burst_busy_out = (beats != 3'h0);
    read_allowed_out = (sr_count == 8'h00);
    termination_on_out = odt_now & (state != ST_SELF_REF);
  end

endmodule // ddrcd_command_decode

// file: testbench/ddrcd_checker.sv
`timescale 1ns/1ns
`include "ddrcd_defines.vh"
// ==========
// port checker
module ddrcd_checker (
  input wire ref_clk_in,
  input wire reset_n_in,
  input wire [2:0] cmd_out,
  input wire cmd_valid_out,
  input wire [13:0] cmd_addr_out,
  input wire all_banks_out,
  input wire [1:0] power_state_out,
  input wire burst_busy_out,
  input wire [3:0] open_rows_out,
  input wire read_allowed_out,
  input wire termination_on_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence sr_exit_s;
    power_state_out == 2'h3 ##1 power_state_out == 2'h0;
  endsequence
  sequence wr_s;
    cmd_valid_out && cmd_out == `DDRCD_CMD_WRITE;
  endsequence
  valid_pulse_a: assert property (cmd_valid_out |=> !cmd_valid_out) else $error("valid too long");
  valid_code_a: assert property (cmd_valid_out |-> cmd_out inside {[3'h1:3'h6]}) else $error("bad code");
  cmd_hold_a: assert property (!cmd_valid_out |-> $stable(cmd_out)) else $error("cmd moved");
  all_flag_a: assert property (cmd_valid_out && cmd_out == 3'h3 |-> all_banks_out == cmd_addr_out[10])
    else $error("all banks flag");
  burst_run_a: assert property (wr_s |-> ##1 burst_busy_out [*8]) else $error("burst cut");
  quiet_low_a: assert property (power_state_out != 0 && $past(power_state_out) != 0 |-> !cmd_valid_out)
    else $error("cmd in low power");
  sr_term_a: assert property (power_state_out == 3 && $past(power_state_out) == 3 |-> !termination_on_out)
    else $error("term in self refresh");
  sr_read_a: assert property (sr_exit_s |=> !read_allowed_out) else $error("read early");
  pd_kind_a: assert property ($changed(power_state_out) && power_state_out == 1 |-> open_rows_out != 0)
    else $error("pd kind");
endmodule // ddrcd_checker

// file: testbench/ddrcd_ctrl_model.sv
`timescale 1ns/1ns
// ==========
// controller model
module ddrcd_ctrl_model (
  output logic link_clk_out,
  output logic [3:0] enc_out,
  output logic gate_out,
  output logic [2:0] bank_out,
  output logic [13:0] addr_out,
  output logic mask_out,
  output logic [15:0] data_out,
  output logic term_out
);
  initial link_clk_out = 1'b0;
  initial {enc_out, gate_out, bank_out, addr_out, mask_out, data_out, term_out} = {4'hf, 1'b1, 35'h0};
  // free running: power-down needs a stable clock
  always #80 link_clk_out = ~link_clk_out;
  // pins change mid-period, well ahead of setup; term always defined
  task automatic send(input logic [3:0] e, input logic g, input logic [2:0] b, input logic [13:0] a,
                      input logic m, input logic [15:0] d);
    @(negedge link_clk_out);
    #1;
    {enc_out, gate_out, bank_out, addr_out, mask_out, data_out} = {e, g, b, a, m, d};
    term_out = ~g;
    @(posedge link_clk_out);
  endtask
endmodule // ddrcd_ctrl_model

// file: testbench/tb_ddrcd_command_decode.sv
`timescale 1ns/1ns
// ==========
// bench top
module tb_ddrcd_command_decode;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic link_clk_in, chip_sel_n_in, row_strobe_n_in, col_strobe_n_in, write_en_n_in, clk_gate_in;
  logic termination_ctl_in, write_mask_in, cmd_valid_out, all_banks_out, auto_precharge_out;
  logic burst_busy_out, read_allowed_out, termination_on_out, write_strobe_out;
  logic [2:0] bank_sel_in, cmd_out, cmd_bank_out;
  logic [13:0] addr_in, cmd_addr_out;
  logic [15:0] write_data_in, write_data_out;
  logic [1:0] power_state_out;
  logic [3:0] open_rows_out;
  logic [31:0] lf = 32'hd528;
  int err_total = 0;
  int comparisons = 0;
  int nv = 0;
  int ns = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  ddrcd_ctrl_model ddrcd_ctrl_model_inst (.link_clk_out(link_clk_in), .gate_out(clk_gate_in),
    .enc_out({chip_sel_n_in, row_strobe_n_in, col_strobe_n_in, write_en_n_in}), .bank_out(bank_sel_in),
    .addr_out(addr_in), .mask_out(write_mask_in), .data_out(write_data_in), .term_out(termination_ctl_in));
  ddrcd_command_decode ddrcd_command_decode_inst (.*);
  always @(posedge ref_clk_in) begin
    nv += (cmd_valid_out === 1'b1);
    ns += (write_strobe_out === 1'b1);
  end
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d of %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic nop(input int n);
    repeat (n) ddrcd_ctrl_model_inst.send(4'h7, 1'b1, 3'h0, 14'h0, 1'b0, 16'h0);
  endtask
  // command, then idles or deselects with junk pins; a write burst rides on them
  task automatic cmd(input logic [3:0] e, input logic [2:0] x, input logic f);
    logic [13:0] a;
    logic [2:0] b;
    int v0;
    int s0;
    int es;
    logic [15:0] ed;
    ed = 16'h0;
    lf = nx(lf);
    a = {lf[13:11], f, lf[9:0]};
    b = lf[18:16];
    v0 = nv;
    s0 = ns;
    es = 0;
    ddrcd_ctrl_model_inst.send(e, 1'b1, b, a, 1'b0, lf[31:16]);
    for (int i = 0; i < 5; i++) begin
      lf = nx(lf);
      es += (x == 3'h5 && i < 4 && !lf[5]);
      if (x == 3'h5 && i < 4 && !lf[5]) ed = lf[31:16];
      ddrcd_ctrl_model_inst.send(lf[20] ? {1'b1, lf[19:17]} : 4'h7, 1'b1, 3'h0, 14'h0, lf[5], lf[31:16]);
    end
    chk("valid", nv - v0, 1);
    chk("cmd", cmd_out, x);
    chk("addr", cmd_addr_out, a);
    chk("bank", cmd_bank_out, b);
    chk("beats", ns - s0, es);
    chk("autopre", auto_precharge_out, (x == 3'h5 || x == 3'h6) && f);
    chk("allbanks", all_banks_out, x == 3'h3 && f);
    if (es > 0) chk("wdata", write_data_out, ed);
  endtask
  task automatic low(input logic [3:0] e, input logic [1:0] st);
    int v0;
    v0 = nv;
    ddrcd_ctrl_model_inst.send(e, 1'b0, 3'h0, 14'h0, 1'b0, 16'h0);
    repeat (3) begin
      lf = nx(lf);
      ddrcd_ctrl_model_inst.send(lf[3:0], 1'b0, lf[6:4], lf[19:6], 1'b0, lf[31:16]);
    end
    chk("state", power_state_out, st);
    chk("term", termination_on_out, st != 2'h3);
    chk("quiet", nv - v0, 0);
    nop(4);
    chk("wake", power_state_out, 2'h0);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    #1 reset_n_in = 1'b1;
    // first gate-high edge reads as an exit, so no command there
    nop(2);
    for (int i = 0; i < 6; i++) cmd(i[3:0], i[2:0] + 3'h1, lf[9]);
    cmd(4'h3, 3'h4, 1'b0);
    low(4'h7, 2'h1);
    cmd(4'h2, 3'h3, 1'b1);
    chk("rows", open_rows_out, 4'h0);
    low(4'h7, 2'h2);
    low(4'h1, 2'h3);
    chk("rd_ok", read_allowed_out, 1'b0);
    nop(193);
    chk("rd_ok", read_allowed_out, 1'b0);
    nop(5);
    chk("rd_ok", read_allowed_out, 1'b1);
    test_done;
  end
  initial begin
    #200000;
    err_total++;
    test_done;
  end
endmodule // tb_ddrcd_command_decode
bind ddrcd_command_decode ddrcd_checker ddrcd_checker_inst (.*);
